// file: aite_ctrl.sv
// Analog input trigger, expansion select, input clock and DAC power-on control
//
// Functional notes
// - Five channel high bits drive expansion select
// - Select valid one sample before, held through
// - Nine-bit channel addresses 8 units, 512 lines
// - High trigger level means active
// - Triggered start while inactive withholds sampling
// - Sampling starts on first rising trigger edge
// - One-shot or gated per procedure setting
// - No trigger setting ignores trigger pin
// - Unconnected trigger reads active via pull-up
// - Power-on DAC code gives bipolar zero
// - Unipolar DAC power-on code is mid-scale
// - Internal input clock output buffers sample tick
`timescale 1ns/1ps
module aite_ctrl #(
   parameter logic [15:0] SAMPLE_DIV = aite_pkg::SAMPLE_DIV_RST
) (
   input wire logic CLOCK,
   input wire logic RST,
   input wire logic START,
   input wire logic STOP,
   input wire aite_pkg::aite_trig_mode_t HW_TRIGGER_SETTING,
   input wire aite_pkg::aite_chan_t NEXT_CHAN,
   input wire logic EXT_INPUT_TRIGGER,
   input wire logic [1:0] DAC_UNIPOLAR,
   output logic [aite_pkg::EXP_W-1:0] EXP_SEL,
   output logic SAMPLE_STROBE,
   output logic [aite_pkg::CHAN_W-1:0] SAMPLE_CHAN,
   output logic CHAN_TAKEN,
   output logic INT_INPUT_CLOCK_OUT,
   output logic SAMPLING_ACTIVE,
   output logic [aite_pkg::DAC_W-1:0] DAC0_INIT,
   output logic [aite_pkg::DAC_W-1:0] DAC1_INIT
);
   // ****************************************
   // Trigger synchroniser
   // ****************************************
   // The pad carries a pull-up, so an open pin arrives here as one
   logic trig_s1_r, trig_s2_r, trig_d_r;
   always_ff @(posedge CLOCK or posedge RST) begin
      // Reset to the pulled-up idle level so release gives no false rising edge
      if (RST) begin
         trig_s1_r <= 1'b1;
         trig_s2_r <= 1'b1;
         trig_d_r <= 1'b1;
      end else begin
         trig_s1_r <= EXT_INPUT_TRIGGER;
         trig_s2_r <= trig_s1_r;
         trig_d_r <= trig_s2_r;
      end
   end
   logic trig_act, trig_rise;
   assign trig_act = trig_s2_r;
   assign trig_rise = trig_s2_r & ~trig_d_r;
   // ****************************************
   // Sample clock divider
   // ****************************************
   logic [15:0] div_r, div_nxt;
   logic tick;
   always_comb begin
      tick = (div_r == 16'h0000);
      div_nxt = tick ? (SAMPLE_DIV - 16'h0001) : (div_r - 16'h0001);
   end
   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) div_r <= 16'h0000;
      else div_r <= div_nxt;
   end
   // ****************************************
   // Acquisition state
   // ****************************************
   aite_pkg::aite_state_t st_r, st_nxt;
   aite_pkg::aite_trig_mode_t mode_r, mode_nxt;
   logic run;
   always_comb begin
      st_nxt = st_r;
      mode_nxt = mode_r;
      case (st_r)
         aite_pkg::AITE_IDLE: begin
            if (START) begin
               mode_nxt = HW_TRIGGER_SETTING;
               if (HW_TRIGGER_SETTING == aite_pkg::AITE_TRIG_NONE) begin
                  st_nxt = aite_pkg::AITE_RUN;
               end else if (trig_act) begin
                  st_nxt = aite_pkg::AITE_RUN;
               end else begin
                  st_nxt = aite_pkg::AITE_ARMED;
               end
            end
         end
         aite_pkg::AITE_ARMED: begin
            if (trig_rise) st_nxt = aite_pkg::AITE_RUN;
         end
         aite_pkg::AITE_RUN: begin
            // Gated mode re-arms so a later rising edge resumes sampling
            if (mode_r == aite_pkg::AITE_TRIG_GATED && !trig_act) begin
               st_nxt = aite_pkg::AITE_ARMED;
            end
         end
         default: st_nxt = aite_pkg::AITE_IDLE;
      endcase
      if (STOP) st_nxt = aite_pkg::AITE_IDLE;
   end
   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         st_r <= aite_pkg::AITE_IDLE;
         mode_r <= aite_pkg::AITE_TRIG_NONE;
      end else begin
         st_r <= st_nxt;
         mode_r <= mode_nxt;
      end
   end
   assign run = (st_r == aite_pkg::AITE_RUN);
   // ****************************************
   // Channel pipeline
   // ****************************************
   // The channel is latched one tick ahead so its select lines settle a full period early
   aite_pkg::aite_chan_t pend_r, pend_nxt;
   logic [aite_pkg::CHAN_W-1:0] samp_r, samp_nxt;
   logic strobe_nxt, strobe_r, clk_nxt, clk_r;
   always_comb begin
      pend_nxt = pend_r;
      samp_nxt = samp_r;
      strobe_nxt = 1'b0;
      clk_nxt = tick;
      if (!run) begin
         pend_nxt.valid = 1'b0;
      end else if (tick) begin
         if (pend_r.valid) begin
            strobe_nxt = 1'b1;
            samp_nxt = pend_r.chan;
         end
         pend_nxt = NEXT_CHAN;
      end
   end
   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         pend_r <= '0;
         samp_r <= '0;
         strobe_r <= 1'b0;
         clk_r <= 1'b0;
      end else begin
         pend_r <= pend_nxt;
         samp_r <= samp_nxt;
         strobe_r <= strobe_nxt;
         clk_r <= clk_nxt;
      end
   end
   assign CHAN_TAKEN = run & tick;
   // Top five bits of nine select one of 32 groups of 16 lines
   assign EXP_SEL = pend_r.valid ? pend_r.chan[aite_pkg::CHAN_W-1 -: aite_pkg::EXP_W]
                                 : samp_r[aite_pkg::CHAN_W-1 -: aite_pkg::EXP_W];
   assign SAMPLE_STROBE = strobe_r;
   assign SAMPLE_CHAN = samp_r;
   assign INT_INPUT_CLOCK_OUT = clk_r;
   assign SAMPLING_ACTIVE = run;
   // ****************************************
   // DAC power-on codes
   // ****************************************
   assign DAC0_INIT = DAC_UNIPOLAR[0] ? aite_pkg::DAC_UNIPOLAR_MID
                                      : aite_pkg::DAC_BIPOLAR_ZERO;
   assign DAC1_INIT = DAC_UNIPOLAR[1] ? aite_pkg::DAC_UNIPOLAR_MID
                                      : aite_pkg::DAC_BIPOLAR_ZERO;
endmodule

// file: aite_pkg.sv
// Package of constants and carrier types for the analog input trigger and expansion control
package aite_pkg;
   // ****************************************
   // Widths and sizes
   // ****************************************
   localparam int CHAN_W = 9;
   localparam int EXP_W = 5;
   localparam int DAC_W = 16;
   localparam int MAX_UNITS = 8;
   localparam int LINES_PER_UNIT = 64;
   localparam int MAX_LINES = MAX_UNITS * LINES_PER_UNIT;
   // ****************************************
   // Power-on codes and timing
   // ****************************************
   localparam logic [DAC_W-1:0] DAC_BIPOLAR_ZERO = 16'h8000;
   localparam logic [DAC_W-1:0] DAC_UNIPOLAR_MID = 16'h8000;
   localparam logic [15:0] SAMPLE_DIV_RST = 16'h0064;
   localparam int CLK_PERIOD_NS = 10;
   // ****************************************
   // Trigger modes, acquisition states and channel carrier
   // ****************************************
   typedef enum logic [1:0] {
      AITE_TRIG_NONE = 2'h0,
      AITE_TRIG_ONESHOT = 2'h1,
      AITE_TRIG_GATED = 2'h2
   } aite_trig_mode_t;
   typedef enum logic [2:0] {
      AITE_IDLE = 3'h1,
      AITE_ARMED = 3'h2,
      AITE_RUN = 3'h4
   } aite_state_t;
   typedef struct packed {
      logic valid;
      logic [CHAN_W-1:0] chan;
   } aite_chan_t;
endpackage

// file: aite_trig_src.sv
// Trigger source model with the pad pull-up
`timescale 1ns/1ps
module aite_trig_src (
   input wire logic DRV,
   input wire logic LVL,
   output logic PIN
);
   // A released pin floats high through the pull-up
   assign PIN = DRV ? LVL : 1'b1;
endmodule

// file: aite_chk.sv
// Checker for the trigger and expansion control
`timescale 1ns/1ps
module aite_chk #(parameter logic [15:0] SAMPLE_DIV = 16'h0064) (
   input wire logic CLOCK,
   input wire logic RST,
   input wire logic STOP,
   input wire aite_pkg::aite_trig_mode_t HW_TRIGGER_SETTING,
   input wire aite_pkg::aite_chan_t NEXT_CHAN,
   input wire logic EXT_INPUT_TRIGGER,
   input wire logic [4:0] EXP_SEL,
   input wire logic SAMPLE_STROBE,
   input wire logic [8:0] SAMPLE_CHAN,
   input wire logic CHAN_TAKEN,
   input wire logic INT_INPUT_CLOCK_OUT,
   input wire logic SAMPLING_ACTIVE
);
   localparam int P = SAMPLE_DIV;
   localparam int Q = P + 1;
   default clocking @(posedge CLOCK); endclocking
   default disable iff (RST);
   sel_bits_a: assert property (SAMPLE_STROBE |-> $past(EXP_SEL) == SAMPLE_CHAN[8:4])
      else $error("sel bits wrong");
   sel_hold_a: assert property (SAMPLE_STROBE |-> $past(EXP_SEL, P) == $past(EXP_SEL))
      else $error("sel not held");
   strobe_src_a: assert property (SAMPLE_STROBE |-> $past(CHAN_TAKEN, Q) &&
      $past(NEXT_CHAN.chan, Q) == SAMPLE_CHAN) else $error("sample chan wrong");
   taken_run_a: assert property (CHAN_TAKEN |-> SAMPLING_ACTIVE)
      else $error("taken while idle");
   clk_per_a: assert property (INT_INPUT_CLOCK_OUT |-> ##P INT_INPUT_CLOCK_OUT)
      else $error("clock period wrong");
   // Three sampled edges before a start shows the trigger went through two stages
   trig_sync_a: assert property ($rose(SAMPLING_ACTIVE) && HW_TRIGGER_SETTING != 2'h0
      |-> $past(EXT_INPUT_TRIGGER, 3)) else $error("start too early");
   gate_drop_a: assert property (HW_TRIGGER_SETTING == 2'h2 && SAMPLING_ACTIVE
      && !EXT_INPUT_TRIGGER |-> ##[1:4] !SAMPLING_ACTIVE) else $error("gate ignored");
   run_hold_a: assert property (HW_TRIGGER_SETTING != 2'h2 && SAMPLING_ACTIVE
      && !STOP |=> SAMPLING_ACTIVE) else $error("run dropped");
   cover property (SAMPLE_STROBE);
   cover property ($fell(SAMPLING_ACTIVE) && HW_TRIGGER_SETTING == 2'h2);
   cover property ($rose(SAMPLING_ACTIVE) && HW_TRIGGER_SETTING == 2'h1);
endmodule
bind aite_ctrl aite_chk #(.SAMPLE_DIV(SAMPLE_DIV)) aite_chk_i (.CLOCK(CLOCK), .RST(RST),
   .STOP(STOP), .HW_TRIGGER_SETTING(HW_TRIGGER_SETTING), .NEXT_CHAN(NEXT_CHAN),
   .EXT_INPUT_TRIGGER(EXT_INPUT_TRIGGER), .EXP_SEL(EXP_SEL), .SAMPLE_STROBE(SAMPLE_STROBE),
   .SAMPLE_CHAN(SAMPLE_CHAN), .CHAN_TAKEN(CHAN_TAKEN), .INT_INPUT_CLOCK_OUT(INT_INPUT_CLOCK_OUT),
   .SAMPLING_ACTIVE(SAMPLING_ACTIVE));

// file: aite_ctrl_bench.sv
// Bench for the trigger and expansion control
`timescale 1ns/1ps
module aite_ctrl_bench;
   logic clk = 0, rst = 1, st = 0, stop = 0, en = 1, lv = 0;
   aite_pkg::aite_trig_mode_t md = aite_pkg::AITE_TRIG_NONE;
   aite_pkg::aite_chan_t nc = '0;
   logic [1:0] un = 2'h0;
   logic tr, sb, tk, ac;
   logic [8:0] sc, ex;
   logic [4:0] es, es_q;
   logic [15:0] d0, d1;
   int fails = 0, checks_done = 0, cyc = 0;
   logic [8:0] q[$];
   aite_ctrl #(.SAMPLE_DIV(16'h0004)) aite_ctrl_i (.CLOCK(clk), .RST(rst), .START(st),
      .STOP(stop), .HW_TRIGGER_SETTING(md), .NEXT_CHAN(nc), .EXT_INPUT_TRIGGER(tr),
      .DAC_UNIPOLAR(un), .EXP_SEL(es), .SAMPLE_STROBE(sb), .SAMPLE_CHAN(sc), .CHAN_TAKEN(tk),
      .INT_INPUT_CLOCK_OUT(), .SAMPLING_ACTIVE(ac), .DAC0_INIT(d0), .DAC1_INIT(d1));
   aite_trig_src aite_trig_src_i (.DRV(en), .LVL(lv), .PIN(tr));
   initial forever #5 clk = ~clk;
   task automatic cmp(input string n, input logic [15:0] e, input logic [15:0] g);
      checks_done++;
      if (g !== e) begin
         fails++;
         $display("Error %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic end_sim;
      $display("checks %0d fails %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         fails++;
         end_sim();
      end
      if (tk === 1'b1 && nc.valid === 1'b1) q.push_back(nc.chan);
   end
   // es_q holds the select lines of the cycle before the strobe
   always @(posedge clk) begin
      es_q <= es;
      if (sb === 1'b1) begin
         ex = q.pop_front();
         cmp("chan", {7'h0, ex}, {7'h0, sc});
         cmp("sel", {11'h0, ex[8:4]}, {11'h0, es_q});
      end
   end
   task automatic run(input aite_pkg::aite_trig_mode_t m, input logic e, input logic l);
      md = m;
      en = e;
      lv = l;
      repeat (4) @(negedge clk);
      st = 1;
      @(negedge clk);
      st = 0;
   endtask
   // Ends with invalid channels so nothing is pending when the run stops
   task automatic feed;
      repeat (24) begin
         @(negedge clk);
         nc = {1'b1, 9'($urandom)};
      end
      nc = '0;
      repeat (12) @(negedge clk);
   endtask
   task automatic chk_act(input logic e);
      repeat (4) @(negedge clk);
      cmp("active", {15'h0, e}, {15'h0, ac});
   endtask
   task automatic halt;
      stop = 1;
      @(negedge clk);
      stop = 0;
      chk_act(1'b0);
   endtask
   initial begin
      void'($urandom(32'h5827c985));
      repeat (4) @(negedge clk);
      rst = 0;
      for (int i = 0; i < 4; i++) begin
         un = 2'(i);
         @(negedge clk);
         cmp("dac0", i[0] ? aite_pkg::DAC_UNIPOLAR_MID : aite_pkg::DAC_BIPOLAR_ZERO, d0);
         cmp("dac1", i[1] ? aite_pkg::DAC_UNIPOLAR_MID : aite_pkg::DAC_BIPOLAR_ZERO, d1);
      end
      run(aite_pkg::AITE_TRIG_NONE, 1'b1, 1'b0);
      feed();
      halt();
      run(aite_pkg::AITE_TRIG_ONESHOT, 1'b1, 1'b0);
      chk_act(1'b0);
      lv = 1;
      chk_act(1'b1);
      lv = 0;
      feed();
      halt();
      run(aite_pkg::AITE_TRIG_GATED, 1'b1, 1'b1);
      feed();
      lv = 0;
      chk_act(1'b0);
      lv = 1;
      feed();
      halt();
      run(aite_pkg::AITE_TRIG_ONESHOT, 1'b0, 1'b0);
      chk_act(1'b1);
      halt();
      cmp("left", 16'h0, 16'(q.size()));
      end_sim();
   end
endmodule
